// File: core/car_pkg.sv
package car_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SUBSEC = 8'h08;
  localparam logic [7:0] OFS_TIME = 8'h0C;
  localparam logic [7:0] OFS_DATE = 8'h10;
  localparam logic [7:0] OFS_WKRELOAD = 8'h14;
  localparam logic [7:0] OFS_ALRM_SS = 8'h18;
  localparam logic [7:0] OFS_ALRM = 8'h1C;

  // control register layout, bit 0 is shadow_bypass
  typedef struct packed {
    logic [2:0] wakeup_clock_select;
    logic dst_memo_bit;
    logic hour_back_cmd;
    logic hour_forward_cmd;
    logic wakeup_enable;
    logic alarm_a_enable;
    logic shadow_bypass;
  } car_ctrl_s;
  localparam int CTRL_W = 9;
  localparam car_ctrl_s CTRL_RESET = '0;

  // status register bit positions
  localparam int ST_SYNCED = 0;
  localparam int ST_WK_ALLOWED = 1;
  localparam int ST_WK_FLAG = 2;
  localparam int ST_LOCKED = 3;

  // time register field positions
  localparam int TM_SEC_LSB = 0;
  localparam int TM_MIN_LSB = 8;
  localparam int TM_HOUR_LSB = 16;

  // calendar limits and sub-second prescale
  localparam logic [7:0] SUBSEC_RELOAD = 8'hFF;
  localparam logic [5:0] SEC_LAST = 6'h3B;
  localparam logic [5:0] MIN_LAST = 6'h3B;
  localparam logic [4:0] HOUR_LAST = 5'h17;

  // wakeup clock selection
  localparam int WK_RELOAD_W = 16;
  localparam logic [3:0] WK_DIV16 = 4'hF;
  localparam logic [3:0] WK_DIV8 = 4'h7;
  localparam logic [3:0] WK_DIV4 = 4'h3;
  localparam logic [3:0] WK_DIV2 = 4'h1;

  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;

endpackage

// File: core/car_sync.sv
`timescale 1ns/1ps
module car_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous level in
  input wire logic async_in,
  // synchronised level and its rising edge
  output logic level,
  output logic rise
);

  logic meta;
  logic stage2;
  logic stage3;

  // meta is read only by stage2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      meta <= async_in;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  assign level = stage2;
  assign rise = stage2 & ~stage3;

endmodule

// File: core/car_top.sv
`timescale 1ns/1ps
// Summary of operation
// - hour forward/back adjusts running calendar one hour
// - memo bit stored, readable, no counting effect
// - control changes reach kernel side two ticks later
// - write-allowed flag rises after wakeup disable synchronises
// - re-enabling wakeup restarts counter from new reload
// - each kernel tick with no read lock held copies calendar, sets synced flag
// - subsecond/time read freezes higher shadows until date
// - bypass returns live counters directly
// - bypass calendar read adds one wait cycle
// - system reset clears shadows and synced flag
// - calendar, control, reload, alarms use backup reset only
// - calendar keeps counting through system reset
// - backup reset stops and clears backup-domain registers; subsec loads FF, write-allowed sets
// - shadow bypass resets to zero
// - wakeup counter at zero sets flag and reloads
module car_top (
  // clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic bkp_resetn,
  // kernel clock pin, sampled as a level
  input wire logic rtc_kernel_clock,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic [1:0] hresp
);

  // kernel tick: one-cycle enable per kernel clock period
  logic rtc_tick;
  car_sync u_kernel_sync (
    .clk(hclk),
    .rst_n(bkp_resetn),
    .async_in(rtc_kernel_clock),
    .level(),
    .rise(rtc_tick)
  );

  // backup-domain state
  car_pkg::car_ctrl_s ctrl;
  car_pkg::car_ctrl_s ctrl_s1;
  car_pkg::car_ctrl_s ctrl_s2;
  logic [car_pkg::WK_RELOAD_W-1:0] wk_reload;
  logic [31:0] alrm_ss;
  logic [31:0] alrm;
  logic [7:0] subsec;
  logic [5:0] sec;
  logic [5:0] min;
  logic [4:0] hour;
  logic [15:0] day;
  logic [16:0] wk_count;
  logic [3:0] wk_div;
  logic wk_en_prev;
  logic wk_allowed;
  logic wk_flag;

  // system-reset state
  logic [7:0] subsec_sh;
  logic [31:0] time_sh;
  logic [15:0] day_sh;
  logic synced;
  logic lock_time;
  logic lock_date;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic wait_rd;
  logic [7:0] rd_addr;

  function automatic logic [31:0] time_word(input logic [5:0] s, input logic [5:0] m, input logic [4:0] h);
    logic [31:0] w;
    w = car_pkg::WORD_ZERO;
    w[car_pkg::TM_SEC_LSB +: 6] = s;
    w[car_pkg::TM_MIN_LSB +: 6] = m;
    w[car_pkg::TM_HOUR_LSB +: 5] = h;
    return w;
  endfunction

  function automatic logic is_calendar(input logic [7:0] a);
    return (a == car_pkg::OFS_SUBSEC) || (a == car_pkg::OFS_TIME) || (a == car_pkg::OFS_DATE);
  endfunction

  // read mux; live selects counters instead of shadows
  function automatic logic [31:0] rd_word(input logic [7:0] a, input logic live, input car_pkg::car_ctrl_s c,
                                          input logic [31:0] st, input logic [31:0] live_tm,
                                          input logic [31:0] sh_tm, input logic [7:0] ss_l, input logic [7:0] ss_s,
                                          input logic [15:0] d_l, input logic [15:0] d_s,
                                          input logic [15:0] rl, input logic [31:0] ass, input logic [31:0] aa);
    logic [31:0] w;
    w = car_pkg::WORD_ZERO;
    if (a == car_pkg::OFS_CTRL) begin
      w[car_pkg::CTRL_W-1:0] = c;
    end else if (a == car_pkg::OFS_STATUS) begin
      w = st;
    end else if (a == car_pkg::OFS_SUBSEC) begin
      w[7:0] = live ? ss_l : ss_s;
    end else if (a == car_pkg::OFS_TIME) begin
      w = live ? live_tm : sh_tm;
    end else if (a == car_pkg::OFS_DATE) begin
      w[15:0] = live ? d_l : d_s;
    end else if (a == car_pkg::OFS_WKRELOAD) begin
      w[car_pkg::WK_RELOAD_W-1:0] = rl;
    end else if (a == car_pkg::OFS_ALRM_SS) begin
      w = ass;
    end else if (a == car_pkg::OFS_ALRM) begin
      w = aa;
    end
    return w;
  endfunction

  // bus decode
  // hsize is ignored: every register is one aligned word
  wire [7:0] a_addr = haddr[7:0];
  wire a_take = hsel & htrans[1] & hready;
  wire a_read = a_take & ~hwrite;
  wire a_byp_cal = a_read & ctrl.shadow_bypass & is_calendar(a_addr);
  wire a_shadow_rd = a_read & ~ctrl.shadow_bypass;
  // writes land in the data phase, when hwdata is valid
  wire w_ctrl = wr_pend & (wr_addr == car_pkg::OFS_CTRL);
  wire w_status = wr_pend & (wr_addr == car_pkg::OFS_STATUS);
  wire w_reload = wr_pend & (wr_addr == car_pkg::OFS_WKRELOAD) & wk_allowed;
  wire w_alrm_ss = wr_pend & (wr_addr == car_pkg::OFS_ALRM_SS);
  wire w_alrm = wr_pend & (wr_addr == car_pkg::OFS_ALRM);
  wire car_pkg::car_ctrl_s w_val = hwdata[car_pkg::CTRL_W-1:0];

  // status layout from bit 0: synced, write allowed, wakeup flag, read lock
  wire [31:0] status_word = {28'h000_0000, lock_time | lock_date, wk_flag, wk_allowed, synced};
  wire [31:0] live_time = time_word(sec, min, hour);

  // hour adjust: pending command applied once it crossed two ticks
  wire fwd_go = rtc_tick & ctrl_s1.hour_forward_cmd & ctrl.hour_forward_cmd;
  wire back_go = rtc_tick & ctrl_s1.hour_back_cmd & ctrl.hour_back_cmd & ~fwd_go;

  // calendar counting
  wire sec_tick = rtc_tick & (subsec == 8'h00);
  wire sec_wrap = sec == car_pkg::SEC_LAST;
  wire min_wrap = min == car_pkg::MIN_LAST;
  wire hour_wrap = hour == car_pkg::HOUR_LAST;
  wire min_tick = sec_tick & sec_wrap;
  wire hour_tick = min_tick & min_wrap;
  wire day_tick = hour_tick & hour_wrap;
  // an adjust never carries into the day count: the hour just wraps
  wire [4:0] hour_up = hour_wrap ? 5'h00 : hour + 5'h01;
  wire [4:0] hour_down = (hour == 5'h00) ? car_pkg::HOUR_LAST : hour - 5'h01;
  wire [4:0] next_hour = fwd_go ? hour_up : back_go ? hour_down : hour_tick ? hour_up : hour;

  // wakeup clock: kernel divided by 16/8/4/2, or the seconds tick
  wire [3:0] wk_mask = (ctrl_s2.wakeup_clock_select[1:0] == 2'h0) ? car_pkg::WK_DIV16 :
                       (ctrl_s2.wakeup_clock_select[1:0] == 2'h1) ? car_pkg::WK_DIV8 :
                       (ctrl_s2.wakeup_clock_select[1:0] == 2'h2) ? car_pkg::WK_DIV4 : car_pkg::WK_DIV2;
  wire wk_step = ctrl_s2.wakeup_clock_select[2] ? sec_tick : (rtc_tick & ((wk_div & wk_mask) == wk_mask));
  // select 11 in the top bits adds a seventeenth count bit
  wire [16:0] wk_load = {&ctrl_s2.wakeup_clock_select[2:1], wk_reload};
  wire wk_start = ctrl_s2.wakeup_enable & ~wk_en_prev;
  wire wk_zero = ctrl_s2.wakeup_enable & ~wk_start & wk_step & (wk_count == 17'h0_0000);

  // shadow copy is suppressed while a read sequence holds a lock
  // otherwise time and date could come from two different kernel ticks
  wire sh_copy = rtc_tick & ~lock_time & ~lock_date;

  // control register: backup reset only
  always_ff @(posedge hclk or negedge bkp_resetn) begin
    if (!bkp_resetn) begin
      ctrl <= car_pkg::CTRL_RESET;
    end else begin
      if (w_ctrl) begin
        ctrl.shadow_bypass <= w_val.shadow_bypass;
        ctrl.alarm_a_enable <= w_val.alarm_a_enable;
        ctrl.wakeup_enable <= w_val.wakeup_enable;
        ctrl.dst_memo_bit <= w_val.dst_memo_bit;
        if (wk_allowed) begin
          ctrl.wakeup_clock_select <= w_val.wakeup_clock_select;
        end
      end
      // a new command wins over completion of the previous one
      ctrl.hour_forward_cmd <= (w_ctrl & w_val.hour_forward_cmd) | (ctrl.hour_forward_cmd & ~fwd_go);
      ctrl.hour_back_cmd <= (w_ctrl & w_val.hour_back_cmd) | (ctrl.hour_back_cmd & ~back_go);
    end
  end

  // kernel-side copy of control, two ticks behind the bus write
  always_ff @(posedge hclk or negedge bkp_resetn) begin
    if (!bkp_resetn) begin
      ctrl_s1 <= car_pkg::CTRL_RESET;
      ctrl_s2 <= car_pkg::CTRL_RESET;
    end else if (rtc_tick) begin
      ctrl_s1 <= ctrl;
      ctrl_s2 <= ctrl_s1;
    end
  end

  // reload and alarm storage
  always_ff @(posedge hclk or negedge bkp_resetn) begin
    if (!bkp_resetn) begin
      wk_reload <= '0;
      alrm_ss <= car_pkg::WORD_ZERO;
      alrm <= car_pkg::WORD_ZERO;
    end else begin
      // reload moves only while the timer is stopped, so a running count never sees a torn value
      if (w_reload) begin
        wk_reload <= hwdata[car_pkg::WK_RELOAD_W-1:0];
      end
      if (w_alrm_ss) begin
        alrm_ss <= hwdata;
      end
      if (w_alrm) begin
        alrm <= hwdata;
      end
    end
  end

  // live calendar; system reset does not touch it
  always_ff @(posedge hclk or negedge bkp_resetn) begin
    if (!bkp_resetn) begin
      subsec <= car_pkg::SUBSEC_RELOAD;
      sec <= '0;
      min <= '0;
      hour <= '0;
      day <= '0;
    end else begin
      if (rtc_tick) begin
        subsec <= (subsec == 8'h00) ? car_pkg::SUBSEC_RELOAD : subsec - 8'h01;
      end
      if (min_tick) begin
        sec <= 6'h00;
      end else if (sec_tick) begin
        sec <= sec + 6'h01;
      end
      if (hour_tick) begin
        min <= 6'h00;
      end else if (min_tick) begin
        min <= min + 6'h01;
      end
      hour <= next_hour;
      if (day_tick & ~fwd_go & ~back_go) begin
        day <= day + 16'h0001;
      end
    end
  end

  // wakeup timer
  always_ff @(posedge hclk or negedge bkp_resetn) begin
    if (!bkp_resetn) begin
      wk_div <= '0;
      wk_en_prev <= 1'b0;
      wk_allowed <= 1'b1;
      wk_count <= '0;
      wk_flag <= 1'b0;
    end else begin
      if (rtc_tick) begin
        wk_div <= wk_div + 4'h1;
      end
      wk_en_prev <= ctrl_s2.wakeup_enable;
      wk_allowed <= ~ctrl_s2.wakeup_enable;
      if (wk_start | wk_zero) begin
        wk_count <= wk_load;
      end else if (ctrl_s2.wakeup_enable & wk_step) begin
        wk_count <= wk_count - 17'h0_0001;
      end
      // set wins over a software clear in the same cycle
      wk_flag <= wk_zero | (wk_flag & ~(w_status & ~hwdata[car_pkg::ST_WK_FLAG]));
    end
  end

  // shadows, synced flag and read locks: system reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      subsec_sh <= '0;
      time_sh <= car_pkg::WORD_ZERO;
      day_sh <= '0;
      synced <= 1'b0;
      lock_time <= 1'b0;
      lock_date <= 1'b0;
    end else begin
      if (sh_copy) begin
        subsec_sh <= subsec;
        time_sh <= live_time;
        day_sh <= day;
      end
      synced <= sh_copy | (synced & ~(w_status & ~hwdata[car_pkg::ST_SYNCED]));
      if (a_shadow_rd & (a_addr == car_pkg::OFS_DATE)) begin
        lock_time <= 1'b0;
        lock_date <= 1'b0;
      end else if (a_shadow_rd & (a_addr == car_pkg::OFS_SUBSEC)) begin
        lock_time <= 1'b1;
        lock_date <= 1'b1;
      end else if (a_shadow_rd & (a_addr == car_pkg::OFS_TIME)) begin
        lock_date <= 1'b1;
      end
    end
  end

  // ahb-lite slave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata <= car_pkg::WORD_ZERO;
      hresp <= car_pkg::RESP_OKAY;
      wr_pend <= 1'b0;
      wr_addr <= '0;
      wait_rd <= 1'b0;
      rd_addr <= '0;
    end else begin
      // no access is ever refused, so the response stays okay
      hresp <= car_pkg::RESP_OKAY;
      wr_pend <= a_take & hwrite;
      wr_addr <= a_addr;
      // a bypass calendar read waits one cycle, then takes the live counters
      if (wait_rd) begin
        hreadyout <= 1'b1;
        wait_rd <= 1'b0;
        hrdata <= rd_word(rd_addr, 1'b1, ctrl, status_word, live_time, time_sh, subsec, subsec_sh,
                          day, day_sh, wk_reload, alrm_ss, alrm);
      end else if (a_byp_cal) begin
        hreadyout <= 1'b0;
        wait_rd <= 1'b1;
        rd_addr <= a_addr;
      end else if (a_read) begin
        hrdata <= rd_word(a_addr, 1'b0, ctrl, status_word, live_time, time_sh, subsec, subsec_sh,
                          day, day_sh, wk_reload, alrm_ss, alrm);
      end
    end
  end

endmodule

// File: test/car_chk.sv
`timescale 1ns/1ps
module car_chk (
  // clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic bkp_resetn,
  input wire logic rtc_kernel_clock,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] hresp
);
  logic ph_rd;
  logic ph_wr;
  logic byp;
  logic memo;
  logic lock;
  logic [7:0] ph_a;
  wire take = hsel && htrans[1] && hready;
  wire done = (ph_rd || ph_wr) && hreadyout;
  wire [7:0] a = haddr[7:0];
  wire cal = a == car_pkg::OFS_SUBSEC || a == car_pkg::OFS_TIME || a == car_pkg::OFS_DATE;
  wire sh_rd = done && ph_rd && !byp;
  // lock is tracked at completion; the bench never reads status back to back with a shadow read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_rd <= 1'b0;
      ph_wr <= 1'b0;
      ph_a <= 8'h00;
      lock <= 1'b0;
    end else begin
      if (take) begin
        {ph_rd, ph_wr, ph_a} <= {!hwrite, hwrite, a};
      end else if (hreadyout) begin
        {ph_rd, ph_wr} <= 2'h0;
      end
      if (sh_rd && (ph_a == car_pkg::OFS_SUBSEC || ph_a == car_pkg::OFS_TIME)) begin
        lock <= 1'b1;
      end else if (sh_rd && ph_a == car_pkg::OFS_DATE) begin
        lock <= 1'b0;
      end
    end
  end
  always_ff @(posedge hclk or negedge bkp_resetn) begin
    if (!bkp_resetn) begin
      byp <= 1'b0;
      memo <= 1'b0;
    end else if (done && ph_wr && ph_a == car_pkg::OFS_CTRL) begin
      byp <= hwdata[0];
      memo <= hwdata[5];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_wait_bounded: assert property (!hreadyout |=> hreadyout)
    else $error("wait state lasted more than one cycle");
  a_bypass_wait: assert property (take && !hwrite && cal && byp |=> !hreadyout ##1 hreadyout)
    else $error("bypass calendar read without exactly one wait");
  a_no_wait: assert property (take && !(!hwrite && cal && byp) |=> hreadyout)
    else $error("unexpected wait state");
  a_resp_okay: assert property (hresp == car_pkg::RESP_OKAY)
    else $error("response not okay");
  a_ctrl_readback: assert property (done && ph_rd && ph_a == car_pkg::OFS_CTRL |-> hrdata[0] == byp && hrdata[5] == memo)
    else $error("control readback differs from last write");
  a_lock_status: assert property (done && ph_rd && ph_a == car_pkg::OFS_STATUS |-> hrdata[3] == lock)
    else $error("read lock flag wrong");
  a_time_range: assert property (done && ph_rd && ph_a == car_pkg::OFS_TIME |-> hrdata[20:16] <= car_pkg::HOUR_LAST
    && hrdata[13:8] <= car_pkg::MIN_LAST && hrdata[5:0] <= car_pkg::SEC_LAST)
    else $error("time field out of range");
  a_reset_clear: assert property ($rose(hresetn) |-> hrdata == car_pkg::WORD_ZERO && hreadyout)
    else $error("bus outputs not cleared by system reset");
  c_bypass_wait: cover property (take && !hwrite && cal && byp);
  c_lock_seen: cover property (done && ph_rd && ph_a == car_pkg::OFS_STATUS && lock);
  c_ctrl_write: cover property (done && ph_wr && ph_a == car_pkg::OFS_CTRL);
endmodule
bind car_top car_chk u_chk (.hclk, .hresetn, .bkp_resetn, .rtc_kernel_clock, .hsel, .haddr, .htrans, .hwrite,
  .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp);

// File: test/calendar_access_and_reset_control_test.sv
`timescale 1ns/1ps
module calendar_access_and_reset_control_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic bkp_resetn = 1'b0;
  logic rtc_kernel_clock = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic [31:0] hrdata;
  logic [1:0] hresp;
  wire hready = hreadyout;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] rd;
  logic [31:0] s1;
  logic mon_rd = 1'b0;
  logic memo;
  logic [15:0] rnd = 16'h0035;
  logic [15:0] rl;
  always #50 hclk = ~hclk;
  // kernel clock is offset so its edges never line up with the bus clock
  initial begin
    #3;
    forever #800 rtc_kernel_clock = ~rtc_kernel_clock;
  end
  car_top uut (.hclk(hclk), .hresetn(hresetn), .bkp_resetn(bkp_resetn), .rtc_kernel_clock(rtc_kernel_clock),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic results();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] ex, input logic [31:0] m);
    samples_checked++;
    if ((got & m) !== (ex & m)) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got & m, ex & m);
    end
  endtask
  // for a read, d is the expected word and m the mask of bits that are predictable
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0000_0000;
    if (!w) begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      xfer(1'b0, car_pkg::OFS_STATUS, 32'h0000_0000, 32'h0000_0000);
      n++;
    end while (rd[b] !== v && n < 400);
    chk(32'(rd[b]), 32'(v), 32'h0000_0001);
  endtask
  always @(posedge hclk) begin
    if (mon_rd && hreadyout === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(hrdata, ~hrdata, 32'hFFFF_FFFF);
      end else begin
        chk(hrdata, exp_q.pop_front(), msk_q.pop_front());
      end
      mon_rd <= 1'b0;
    end
    if (hsel && htrans[1] && hready === 1'b1 && !hwrite) begin
      mon_rd <= 1'b1;
    end
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bkp_resetn <= 1'b1;
    xfer(1'b0, car_pkg::OFS_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    xfer(1'b0, car_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_000E);
    xfer(1'b0, 8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
    poll(car_pkg::ST_SYNCED, 1'b1);
    xfer(1'b0, car_pkg::OFS_TIME, 32'h0000_0000, 32'hFFFF_FFFF);
    xfer(1'b0, car_pkg::OFS_DATE, 32'h0000_0000, 32'hFFFF_FFFF);
    xfer(1'b0, car_pkg::OFS_SUBSEC, 32'h0000_0000, 32'h0000_0000);
    s1 = rd;
    repeat (64) @(posedge hclk);
    xfer(1'b0, car_pkg::OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
    xfer(1'b0, car_pkg::OFS_SUBSEC, s1, 32'h0000_00FF);
    xfer(1'b0, car_pkg::OFS_DATE, 32'h0000_0000, 32'h0000_0000);
    xfer(1'b0, car_pkg::OFS_STATUS, 32'h0000_0000, 32'h0000_0008);
    xfer(1'b1, car_pkg::OFS_STATUS, 32'h0000_0000, 32'h0000_0000);
    poll(car_pkg::ST_SYNCED, 1'b1);
    xfer(1'b0, car_pkg::OFS_SUBSEC, 32'h0000_0000, 32'h0000_0000);
    chk(32'(rd !== s1), 32'h0000_0001, 32'h0000_0001);
    xfer(1'b0, car_pkg::OFS_DATE, 32'h0000_0000, 32'h0000_0000);
    rnd = lfsr(rnd);
    memo = rnd[0];
    xfer(1'b1, car_pkg::OFS_CTRL, {26'h000_0000, memo, 5'h01}, 32'h0000_0000);
    xfer(1'b0, car_pkg::OFS_CTRL, {26'h000_0000, memo, 5'h01}, 32'h0000_0021);
    xfer(1'b0, car_pkg::OFS_SUBSEC, 32'h0000_0000, 32'h0000_0000);
    s1 = rd;
    repeat (48) @(posedge hclk);
    xfer(1'b0, car_pkg::OFS_SUBSEC, 32'h0000_0000, 32'h0000_0000);
    chk(32'(rd !== s1), 32'h0000_0001, 32'h0000_0001);
    // hour 0 stepped back must wrap to 23, then forward wraps to 0
    xfer(1'b1, car_pkg::OFS_CTRL, {26'h000_0000, memo, 5'h11}, 32'h0000_0000);
    repeat (80) @(posedge hclk);
    xfer(1'b0, car_pkg::OFS_TIME, 32'h0017_0000, 32'h001F_0000);
    xfer(1'b0, car_pkg::OFS_CTRL, 32'h0000_0000, 32'h0000_0018);
    xfer(1'b1, car_pkg::OFS_CTRL, {26'h000_0000, memo, 5'h09}, 32'h0000_0000);
    repeat (80) @(posedge hclk);
    xfer(1'b0, car_pkg::OFS_TIME, 32'h0000_0000, 32'h001F_0000);
    rnd = lfsr(rnd);
    xfer(1'b1, car_pkg::OFS_CTRL, {26'h000_0000, memo, 5'h01}, 32'h0000_0000);
    xfer(1'b1, car_pkg::OFS_ALRM_SS, {16'h0000, rnd}, 32'h0000_0000);
    xfer(1'b1, car_pkg::OFS_ALRM, {rnd, 16'h0000}, 32'h0000_0000);
    xfer(1'b1, car_pkg::OFS_CTRL, {26'h000_0000, memo, 5'h03}, 32'h0000_0000);
    rl = {12'h000, rnd[3:0]} + 16'h0002;
    xfer(1'b1, car_pkg::OFS_WKRELOAD, {16'h0000, rl}, 32'h0000_0000);
    xfer(1'b1, car_pkg::OFS_CTRL, {23'h00_0000, 3'h3, memo, 5'h07}, 32'h0000_0000);
    poll(car_pkg::ST_WK_ALLOWED, 1'b0);
    poll(car_pkg::ST_WK_FLAG, 1'b1);
    xfer(1'b1, car_pkg::OFS_STATUS, 32'h0000_0000, 32'h0000_0000);
    xfer(1'b0, car_pkg::OFS_STATUS, 32'h0000_0000, 32'h0000_0004);
    poll(car_pkg::ST_WK_FLAG, 1'b1);
    xfer(1'b1, car_pkg::OFS_CTRL, {23'h00_0000, 3'h3, memo, 5'h03}, 32'h0000_0000);
    poll(car_pkg::ST_WK_ALLOWED, 1'b1);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, car_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_000A);
    xfer(1'b0, car_pkg::OFS_CTRL, {23'h00_0000, 3'h3, memo, 5'h03}, 32'h0000_01FF);
    xfer(1'b0, car_pkg::OFS_WKRELOAD, {16'h0000, rl}, 32'hFFFF_FFFF);
    xfer(1'b0, car_pkg::OFS_ALRM, {rnd, 16'h0000}, 32'hFFFF_FFFF);
    @(posedge hclk);
    bkp_resetn <= 1'b0;
    repeat (2) @(posedge hclk);
    bkp_resetn <= 1'b1;
    xfer(1'b0, car_pkg::OFS_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    xfer(1'b0, car_pkg::OFS_ALRM, 32'h0000_0000, 32'hFFFF_FFFF);
    xfer(1'b0, car_pkg::OFS_WKRELOAD, 32'h0000_0000, 32'hFFFF_FFFF);
    results();
  end
endmodule
